// File: usm_pkg.sv
// Shared constants and types for the master SPI serial port
package usm_pkg;
    // Character width and divisor width
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned DIV_W     = 12;
    // Operating mode code that selects master SPI operation
    localparam logic [1:0]  MODE_MSPI = 2'h3;
    // Index of the last of the sixteen clock edges of a frame
    localparam logic [3:0]  LAST_EDGE = 4'hF;
    localparam logic [3:0]  EDGE_RST  = 4'h0;
    // Divisor counter value after reset
    localparam logic [11:0] DIV_RST   = 12'h000;
    // Data values after reset
    localparam logic [7:0]  BYTE_RST  = 8'h00;
    // Data line rests high between frames
    localparam logic        LINE_IDLE = 1'h1;
    // Two-entry buffer fill levels
    localparam logic [1:0]  BUF_EMPTY = 2'h0;
    localparam logic [1:0]  BUF_ONE   = 2'h1;
    localparam logic [1:0]  BUF_FULL  = 2'h2;
    // Transfer controller states
    typedef enum logic {
        USM_IDLE  = 1'b0,
        USM_SHIFT = 1'b1
    } usm_state_t;
endpackage

// File: usm_stream_if.sv
// Valid/ready byte channel between the buffer and the transfer controller
`timescale 1ns/100ps
interface usm_stream_if;
    import usm_pkg::*;
    logic              valid;  // Source holds a byte
    logic              ready;  // Sink takes it this cycle
    logic [DATA_W-1:0] data;   // The byte itself
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface // usm_stream_if

// File: usm_tx_buf.sv
// Two-entry transmit buffer with valid/ready on both sides
`timescale 1ns/100ps
module usm_tx_buf
    import usm_pkg::*;
(
    input  wire logic   core_clk,
    input  wire logic   rst_n,
    usm_stream_if.snk   wr,
    usm_stream_if.src   rd
);
    // All buffer state in one word
    typedef struct packed {
        logic [1:0][DATA_W-1:0] mem;   // Two storage slots
        logic                   wptr;  // Next slot to fill
        logic                   rptr;  // Next slot to drain
        logic [1:0]             cnt;   // Fill level
    } usm_buf_t;

    usm_buf_t cur;      // Registered state
    usm_buf_t next_buf; // Next state
    logic     push;     // Byte accepted
    logic     pop;      // Byte handed on

    // Full and empty are exact, so a stalled drain side blocks the writer
    assign wr.ready = (cur.cnt != BUF_FULL);
    assign rd.valid = (cur.cnt != BUF_EMPTY);
    assign rd.data  = cur.mem[cur.rptr];
    assign push     = wr.valid && wr.ready;
    assign pop      = rd.valid && rd.ready;

    // Slot and level update
    always_comb begin
        next_buf = cur;
        if (push) begin
            next_buf.mem[cur.wptr] = wr.data;
            next_buf.wptr          = ~cur.wptr;
        end
        if (pop) begin
            next_buf.rptr = ~cur.rptr;
        end
        // Simultaneous push and pop keep the level
        if (push && !pop) begin
            next_buf.cnt = (cur.cnt == BUF_EMPTY) ? BUF_ONE : BUF_FULL;
        end else if (pop && !push) begin
            next_buf.cnt = (cur.cnt == BUF_FULL) ? BUF_ONE : BUF_EMPTY;
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_buf;
        end
    end
endmodule // usm_tx_buf

// File: usm_spi_master.sv
// Master SPI operating mode of the serial port: transfer controller and pins
// Summary of operation
// - Mode code 11 alone enables SPI master
// - Controller owns shifters, buffers, baud generator
// - Parity, recovery and separate sequencers off
// - One shared controller sequences both directions
// - Pin control identical in both modes
// - Control bits keep the same positions
// - Only internally generated clock supported
// - Rate is clock over two(divisor+1)
// - Divisor is twelve bits from two parts
// - Divisor zero gives half system clock
// - Polarity and phase select modes 0-3
// - Shift and sample on opposite edges
// - Full duplex over clock, out, in
// - Selectable LSB or MSB first
// - Transmit double buffered while shifting
// - Eight-bit frames, line idles high
// - Writing data starts both-direction transfer
// - Framing, overrun, parity flags read zero
`timescale 1ns/100ps
module usm_spi_master
    import usm_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic [1:0]        operating_mode_select,
    input  wire logic              transmitter_enable_bit,
    input  wire logic              receiver_enable_bit,
    input  wire logic              clock_polarity_bit,
    input  wire logic              clock_phase_bit,
    input  wire logic              lsb_first,
    input  wire logic [3:0]        baud_divisor_high,
    input  wire logic [7:0]        baud_divisor_low,
    input  wire logic              clock_pin_direction,
    input  wire logic [DATA_W-1:0] serial_data_write,
    input  wire logic              serial_data_write_stb,
    output logic                   tx_buffer_empty,
    output logic [DATA_W-1:0]      serial_data_read,
    output logic                   rx_complete,
    input  wire logic              serial_data_read_stb,
    output logic                   tx_complete,
    input  wire logic              tx_complete_clear,
    output logic                   framing_error_flag,
    output logic                   overrun_error_flag,
    output logic                   parity_error_flag,
    output logic                   master_spi_operation,
    output logic                   transfer_busy,
    output logic                   transfer_clock_pin_out,
    output logic                   transfer_clock_pin_oe_n,
    output logic                   serial_out_pin,
    output logic                   serial_out_pin_oe_n,
    input  wire logic              serial_in_pin
);
    // Controller state, one packed word
    typedef struct packed {
        usm_state_t        st;       // Idle or shifting
        logic [DIV_W-1:0]  div_cnt;  // Half-period counter
        logic [3:0]        edge_cnt; // Clock edges done in frame
        logic [DATA_W-1:0] tx_byte;  // Byte being sent
        logic [DATA_W-1:0] rx_shift; // Byte being gathered
        logic              sck;      // Clock pin level
        logic              mosi;     // Data out level
        logic [DATA_W-1:0] rx_data;  // Receive buffer
        logic              rx_full;  // Receive buffer holds a byte
        logic              tx_done;  // Sticky transmit-complete
        logic              in_meta;  // First sync stage
        logic              in_sync;  // Second sync stage
    } usm_core_t;

    usm_core_t         cur;         // Registered state
    usm_core_t         next_core;   // Next state
    logic              active;      // SPI master mode and transmitter on
    logic [DIV_W-1:0]  divisor;     // Assembled baud divisor
    logic              tick;        // Half period elapsed
    logic              frame_done;  // Last edge of the frame now
    logic              load;        // Byte moved into shifter
    logic              lead_edge;   // Coming edge is a leading one
    logic              sample_now;  // Coming edge samples input
    logic              setup_now;   // Coming edge sets up output
    logic [2:0]        out_idx;     // Bit number presented after edge
    logic [DATA_W-1:0] rx_next;     // Receive shifter after sample

    usm_stream_if      wr_ch ();    // Write side of the buffer
    usm_stream_if      rd_ch ();    // Drain side of the buffer

    assign master_spi_operation = (operating_mode_select == MODE_MSPI);
    // only the shared controller runs; the transmitter must be on
    assign active = master_spi_operation && transmitter_enable_bit;
    // twelve-bit divisor, high part over low part
    // Change it only between frames: a count already past it wraps round
    assign divisor = {baud_divisor_high, baud_divisor_low};

    // writes queue into the two-entry buffer
    assign wr_ch.valid     = serial_data_write_stb && active;
    assign wr_ch.data      = serial_data_write;
    assign tx_buffer_empty = wr_ch.ready;

    // controller owns the transmit buffer
    // The receive side needs no queue: one byte is held, newest lost
    usm_tx_buf u_tx_buf (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr       (wr_ch),
        .rd       (rd_ch)
    );

    // half period is divisor+1 clocks; zero gives fclk/2
    assign tick = (cur.st == USM_SHIFT) && (cur.div_cnt == divisor);

    // even edge counts precede a leading edge
    assign lead_edge  = ~cur.edge_cnt[0];
    // phase 0 samples leading, phase 1 samples trailing
    assign sample_now = tick && (lead_edge ^ clock_phase_bit);
    assign setup_now  = tick && !(lead_edge ^ clock_phase_bit);
    assign frame_done = tick && (cur.edge_cnt == LAST_EDGE);

    // a queued byte enters the shifter when it is free
    assign load = active && rd_ch.valid
                  && ((cur.st == USM_IDLE) || frame_done);
    assign rd_ch.ready = load;

    // Bit presented after a setup edge; phase 1 shifts on leading edges
    always_comb begin
        if (clock_phase_bit) begin
            out_idx = cur.edge_cnt[3:1];
        end else begin
            out_idx = 3'(cur.edge_cnt[3:1] + 3'h1);
        end
    end

    // input bit enters from the side that fills first
    always_comb begin
        if (lsb_first) begin
            rx_next = {cur.in_sync, cur.rx_shift[DATA_W-1:1]};
        end else begin
            rx_next = {cur.rx_shift[DATA_W-2:0], cur.in_sync};
        end
    end

    // one controller sequences transmit and receive together
    always_comb begin
        next_core = cur;
        // Input pin passes two flops before anything reads it
        // That delay is why receiving needs a divisor of three or more
        next_core.in_meta = serial_in_pin;
        next_core.in_sync = cur.in_meta;
        // Divisor counter runs only while shifting
        if (cur.st == USM_SHIFT) begin
            next_core.div_cnt = tick ? DIV_RST : 12'(cur.div_cnt + 12'h001);
        end
        // Clock edge and edge count
        if (tick) begin
            next_core.sck      = ~cur.sck;
            next_core.edge_cnt = 4'(cur.edge_cnt + 4'h1);
        end
        // sampling on the opposite edge to setup
        if (sample_now) begin
            next_core.rx_shift = rx_next;
        end
        // setup of next bit; phase 1 sets its last bit on edge 14
        // The closing edge only returns the line to idle
        if (setup_now && !frame_done) begin
            next_core.mosi = lsb_first ? cur.tx_byte[out_idx]
                                       : cur.tx_byte[3'h7 - out_idx];
        end
        // Phase 1 presents the first bit on edge 0
        if (setup_now && clock_phase_bit && (cur.edge_cnt == EDGE_RST)) begin
            next_core.mosi = lsb_first ? cur.tx_byte[0] : cur.tx_byte[7];
        end
        // frame ends after eight bits; line back to idle
        if (frame_done) begin
            next_core.st   = USM_IDLE;
            next_core.mosi = LINE_IDLE;
        end
        // new byte loads, back to back if one waits
        if (load) begin
            next_core.st       = USM_SHIFT;
            next_core.div_cnt  = DIV_RST;
            next_core.edge_cnt = EDGE_RST;
            next_core.tx_byte  = rd_ch.data;
            // Phase 0 must present the first bit before the first edge
            if (!clock_phase_bit) begin
                next_core.mosi = lsb_first ? rd_ch.data[0] : rd_ch.data[7];
            end
        end
        // Receive buffer: reader clears, but a new byte wins
        if (serial_data_read_stb) begin
            next_core.rx_full = 1'b0;
        end
        // A full buffer drops the newest byte, as in normal operation
        if (frame_done && receiver_enable_bit
            && (!cur.rx_full || serial_data_read_stb)) begin
            next_core.rx_data = clock_phase_bit ? rx_next : cur.rx_shift;
            next_core.rx_full = 1'b1;
        end
        // Transmit complete: set wins over clear
        if (tx_complete_clear) begin
            next_core.tx_done = 1'b0;
        end
        if (frame_done && !load) begin
            next_core.tx_done = 1'b1;
        end
        // idle clock follows the polarity bit
        if (next_core.st == USM_IDLE) begin
            next_core.sck = clock_polarity_bit;
        end
        // leaving the mode or disabling aborts the transfer
        if (!active) begin
            next_core.st   = USM_IDLE;
            next_core.sck  = clock_polarity_bit;
            next_core.mosi = LINE_IDLE;
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cur          <= '0;
            // Data line starts at its idle level
            cur.mosi     <= LINE_IDLE;
        end else begin
            cur <= next_core;
        end
    end

    // pin drivers: clock direction follows its direction bit
    // clock always made here, never taken in
    assign transfer_clock_pin_out  = cur.sck;
    assign transfer_clock_pin_oe_n = ~clock_pin_direction;
    // data output driven while transmitter runs
    assign serial_out_pin          = cur.mosi;
    assign serial_out_pin_oe_n     = ~active;
    assign serial_data_read        = cur.rx_data;
    assign rx_complete             = cur.rx_full;
    assign tx_complete             = cur.tx_done;
    assign transfer_busy           = (cur.st == USM_SHIFT);
    assign framing_error_flag      = 1'b0;
    assign overrun_error_flag      = 1'b0;
    assign parity_error_flag       = 1'b0;

    // Helper: clock toggles seen in the current frame
    // Feeds only the frame-length check; no pin depends on it
    logic [4:0] toggles;
    always_ff @(posedge core_clk) begin
        if (!rst_n || load) begin
            toggles <= 5'h00;
        end else if (tick) begin
            toggles <= 5'(toggles + 5'h01);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    mode_gate_a: assert property (
        !master_spi_operation |=> !transfer_busy)
        else $error("transfer outside master SPI mode");

    sck_idle_a: assert property (
        (!transfer_busy && $past(!transfer_busy) && $stable(clock_polarity_bit))
        |-> transfer_clock_pin_out == clock_polarity_bit)
        else $error("idle clock not at polarity level");

    // edge exactly when the divisor count is reached
    edge_time_a: assert property (
        (transfer_busy && cur.div_cnt == divisor && active && !load)
        |=> transfer_clock_pin_out != $past(transfer_clock_pin_out))
        else $error("clock edge missing at divisor count");

    div_zero_a: assert property (
        (divisor == DIV_RST && transfer_busy && active) |-> tick)
        else $error("divisor zero not at half clock rate");

    edge_hold_a: assert property (
        (transfer_busy && !tick && active) |=> $stable(transfer_clock_pin_out))
        else $error("clock changed between ticks");

    frame_len_a: assert property (
        frame_done |-> toggles == 5'h0F)
        else $error("frame not sixteen edges");

    line_idle_a: assert property (
        (!transfer_busy && $past(!transfer_busy)) |-> serial_out_pin)
        else $error("data line not idle high");

    // queued byte starts a transfer next cycle
    start_xfer_a: assert property (
        (!transfer_busy && rd_ch.valid && active) |=> transfer_busy)
        else $error("queued byte did not start");

    // second byte waits while the first shifts
    queue_a: assert property (
        (transfer_busy && wr_ch.valid && tx_buffer_empty && !frame_done)
        |=> rd_ch.valid && transfer_busy)
        else $error("queued byte lost during shifting");

    err_zero_a: assert property (
        !(framing_error_flag || overrun_error_flag || parity_error_flag))
        else $error("receive error flag set");

    // Completion beats a clear in the same cycle
    set_wins_a: assert property (
        (frame_done && !load && tx_complete_clear) |=> tx_complete)
        else $error("completion lost to clear");

    // phase 1 puts the last bit out on edge fourteen
    last_bit_a: assert property (
        (tick && active && clock_phase_bit && cur.edge_cnt == 4'hE)
        |=> serial_out_pin == (lsb_first ? cur.tx_byte[7] : cur.tx_byte[0]))
        else $error("last bit not presented in phase 1");

    // phase 0 presents the first bit before the first edge
    first_bit_a: assert property (
        (load && !clock_phase_bit)
        |=> serial_out_pin == (lsb_first ? cur.tx_byte[0] : cur.tx_byte[7]))
        else $error("first bit not presented in phase 0");

    // a waiting byte follows with no idle gap
    back_to_back_a: assert property (
        (frame_done && load) |=> transfer_busy && cur.edge_cnt == EDGE_RST)
        else $error("queued byte did not follow directly");

    // an unread received byte is never overwritten
    rx_keep_a: assert property (
        (rx_complete && !serial_data_read_stb) |=> $stable(serial_data_read))
        else $error("unread received byte overwritten");

    // Main scenarios
    mode3_c: cover property (
        frame_done && clock_polarity_bit && clock_phase_bit);
    b2b_c: cover property (frame_done && load);
    drop_c: cover property (
        frame_done && cur.rx_full && receiver_enable_bit);
    fast_c: cover property (frame_done && divisor == DIV_RST);
    phase1_c: cover property (frame_done && clock_phase_bit && !clock_polarity_bit);
endmodule // usm_spi_master

// File: usm_slave_model.sv
// Behavioural SPI slave that stands on the far side of the serial port
`timescale 1ns/100ps
module usm_slave_model (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       sck,
    input  wire logic       mosi,
    output logic            miso,
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic       lsb,
    input  wire logic [7:0] reply,
    output logic [7:0]      got,
    output logic [7:0]      frames
);
    logic       sck_q;  // Clock level one cycle ago
    logic [4:0] edges;  // Clock edges seen in this frame
    logic [3:0] bits;   // Bits already shifted out
    logic [7:0] sh;     // Incoming bits
    logic [7:0] nsh;    // Incoming bits with this edge's bit
    logic [7:0] tx;     // Outgoing byte, new for every frame
    logic       lead;   // Edge that leaves the idle level
    logic       samp;   // Edge that samples
    assign lead = (sck_q == cpol);
    assign samp = (lead != cpha);
    assign tx   = reply ^ frames;
    assign nsh  = lsb ? {mosi, sh[7:1]} : {sh[6:0], mosi};
    assign miso = lsb ? tx[bits[2:0]] : tx[3'h7 - bits[2:0]];
    // sample and shift on opposite edges
    always @(posedge core_clk) begin
        // Edges seen a cycle late, so the data read here is settled
        sck_q <= sck;
        if (!rst_n) begin
            edges  <= 5'h00;
            bits   <= 4'h0;
            frames <= 8'h00;
            got    <= 8'h00;
        end else if (sck != sck_q && (lead || edges != 5'h00)) begin
            // A step into the idle level outside a frame is no edge
            edges <= edges + 5'h01;
            if (samp) begin
                sh <= nsh;
            end else if (edges != 5'h00) begin
                bits <= bits + 4'h1;
            end
            // sixteen edges close an eight-bit frame
            if (edges == 5'h0F) begin
                edges  <= 5'h00;
                bits   <= 4'h0;
                frames <= frames + 8'h01;
                got    <= samp ? nsh : sh;
            end
        end
    end
endmodule // usm_slave_model

// File: tb_top.sv
// Self-checking bench for the master SPI serial port
`timescale 1ns/100ps
module tb_top;
    import usm_pkg::*;
    logic              core_clk = 1'b0;     // 40 MHz core clock
    logic              rst_n    = 1'b0;     // Synchronous reset
    logic [1:0]        mode     = 2'h3;     // Operating mode code
    logic              tx_en    = 1'b1;     // Transmitter on
    logic              rx_en    = 1'b1;     // Receiver on
    logic              cpol     = 1'b0;     // Idle clock level
    logic              cpha     = 1'b0;     // Sample on leading edge
    logic              lsb      = 1'b0;     // High bit first
    // clock pin is an output from the start
    logic              dir      = 1'b1;
    logic [11:0]       div      = 12'h003;  // Baud divisor
    logic [DATA_W-1:0] wdata    = 8'h00;    // Byte to send
    logic              wstb     = 1'b0;     // Write strobe
    logic              rstb     = 1'b0;     // Read strobe
    logic              tclr     = 1'b0;     // Clear of send-done flag
    logic [7:0]        reply    = 8'h5A;    // Seed of slave answers
    logic [DATA_W-1:0] rdata;               // Received byte
    logic [7:0]        got;                 // Byte seen by the slave
    logic [7:0]        frames;              // Frames seen by the slave
    logic empty, rxc, txc, fe, ovr, pe, mspi, busy, sck, sck_oe_n, mosi, mosi_oe_n, miso;
    int                err_count   = 0;     // Mismatches
    int                check_count = 0;     // Comparisons

    usm_spi_master u_usm_spi_master (
        .core_clk(core_clk), .rst_n(rst_n), .operating_mode_select(mode),
        .transmitter_enable_bit(tx_en), .receiver_enable_bit(rx_en),
        .clock_polarity_bit(cpol), .clock_phase_bit(cpha), .lsb_first(lsb),
        .baud_divisor_high(div[11:8]), .baud_divisor_low(div[7:0]),
        .clock_pin_direction(dir), .serial_data_write(wdata),
        .serial_data_write_stb(wstb), .tx_buffer_empty(empty),
        .serial_data_read(rdata), .rx_complete(rxc), .serial_data_read_stb(rstb),
        .tx_complete(txc), .tx_complete_clear(tclr), .framing_error_flag(fe),
        .overrun_error_flag(ovr), .parity_error_flag(pe), .master_spi_operation(mspi),
        .transfer_busy(busy), .transfer_clock_pin_out(sck),
        .transfer_clock_pin_oe_n(sck_oe_n), .serial_out_pin(mosi),
        .serial_out_pin_oe_n(mosi_oe_n), .serial_in_pin(miso));

    usm_slave_model u_usm_slave_model (
        .core_clk(core_clk), .rst_n(rst_n), .sck(sck), .mosi(mosi), .miso(miso),
        .cpol(cpol), .cpha(cpha), .lsb(lsb), .reply(reply), .got(got),
        .frames(frames));

    // Free-running core clock
    always #12.5 core_clk = ~core_clk;

    // One comparison, counted, reported only on mismatch
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // A wait ran out: count it and stop
    task automatic hang;
        err_count++;
        end_of_test();
    endtask

    // One-cycle write strobe; the caller decides whether it may be taken
    task automatic put(input logic [7:0] b);
        @(posedge core_clk);
        wdata <= b;
        wstb  <= 1'b1;
        @(posedge core_clk);
        wstb  <= 1'b0;
    endtask

    // Read the byte and clear the send-done flag together
    task automatic clear;
        @(posedge core_clk);
        rstb <= 1'b1;
        tclr <= 1'b1;
        @(posedge core_clk);
        rstb <= 1'b0;
        tclr <= 1'b0;
        @(negedge core_clk);
        check(rxc, 1'b0);
        check(txc, 1'b0);
    endtask

    // Wait for busy, then count busy cycles and clock toggles until idle
    task automatic run(output int len, output int tog);
        int   n;
        logic p;
        n   = 0;
        len = 0;
        tog = 0;
        @(negedge core_clk);
        while (busy !== 1'b1) begin
            @(negedge core_clk);
            n++;
            if (n > 20) hang();
        end
        p = sck;
        while (busy === 1'b1) begin
            len++;
            @(negedge core_clk);
            if (sck !== p) tog++;
            p = sck;
            if (len > 70000) hang();
        end
    endtask

    task automatic t_reset;
        @(negedge core_clk);
        check(busy, 1'b0);
        check(empty, 1'b1);
        check(rxc, 1'b0);
        check(txc, 1'b0);
        check(mosi, LINE_IDLE);
        check(sck, 1'b0);
        check({fe, ovr, pe}, 3'h0);
    endtask

    // only code 11 selects SPI operation
    task automatic t_mode;
        for (int m = 0; m < 3; m++) begin
            @(posedge core_clk);
            mode <= 2'(m);
            put(8'hC3);
            repeat (4) @(negedge core_clk);
            check(mspi, 1'b0);
            check(busy, 1'b0);
            check(mosi_oe_n, 1'b1);
        end
        @(posedge core_clk);
        mode <= MODE_MSPI;
        dir  <= 1'b0;
        @(negedge core_clk);
        check(mspi, 1'b1);
        check(mosi_oe_n, 1'b0);
        check(sck_oe_n, 1'b1);
        @(posedge core_clk);
        dir <= 1'b1;
        @(negedge core_clk);
        check(sck_oe_n, 1'b0);
        check(frames, 8'h00);
    endtask

    // One full-duplex frame in a given clock mode, bit order and divisor
    task automatic t_xfer(input logic p, h, l, e, input logic [11:0] d);
        int         len;
        int         tog;
        logic [7:0] b;
        logic [7:0] r;
        // mode bits change only between frames
        @(posedge core_clk);
        cpol  <= p;
        cpha  <= h;
        lsb   <= l;
        rx_en <= e;
        div   <= d;
        repeat (3) @(negedge core_clk);
        b = {p, h, l, e, d[3:0]} ^ 8'h96;
        r = reply ^ frames;
        check(sck, p);
        put(b);
        run(len, tog);
        @(negedge core_clk);
        // half period lasts divisor plus one cycles
        check(16'(len), 16'(16 * (d + 1)));
        check(16'(tog), 16'h0010);
        check(got, b);
        check(rxc, e);
        // Two-flop input sync needs a divisor of three or more
        if (e && d > 12'h002) check(rdata, r);
        check(txc, 1'b1);
        check(mosi, LINE_IDLE);
        check(sck, p);
        clear();
    endtask

    // two bytes wait while one shifts; a fourth is refused
    task automatic t_queue;
        int         len;
        int         tog;
        logic [7:0] r;
        logic [7:0] f;
        r = reply ^ frames;
        f = frames;
        put(8'h11);
        put(8'h22);
        put(8'h33);
        @(negedge core_clk);
        check(empty, 1'b0);
        put(8'h44);
        run(len, tog);
        @(negedge core_clk);
        check(frames - f, 8'h03);
        check(got, 8'h33);
        // Unread first byte is kept, later ones are lost
        check(rdata, r);
        check({fe, ovr, pe}, 3'h0);
        clear();
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_mode();
        t_xfer(1'b0, 1'b1, 1'b1, 1'b1, 12'h003);
        t_xfer(1'b1, 1'b0, 1'b1, 1'b1, 12'h004);
        t_xfer(1'b1, 1'b1, 1'b0, 1'b1, 12'h103);
        t_xfer(1'b1, 1'b0, 1'b0, 1'b0, 12'h000);
        t_xfer(1'b0, 1'b0, 1'b0, 1'b1, 12'h003);
        t_queue();
        end_of_test();
    end
endmodule // tb_top
